// ==== flio_pkg.sv ====
// Package with register map, field layouts and types for the flexible line configuration block.
package flio_pkg;
    // ************************************************************
    // Register indices (word addresses of 16-bit register words)
    // ************************************************************
    localparam int ADDR_W = 16;
    localparam logic [15:0] IDX_LEVEL = 16'h0AF0;
    localparam logic [15:0] IDX_DIR = 16'h0B22;
    localparam logic [15:0] IDX_PULLUP = 16'h0B4A;
    localparam logic [15:0] IDX_BLOCK = 16'h0B54;
    localparam logic [15:0] IDX_ANALOG = 16'h0B40;
    localparam logic [15:0] IDX_RUN = 16'hABE0;
    localparam logic [15:0] IDX_SEL = 16'hAC44;
    localparam logic [15:0] IDX_LINE = 16'h07D0;
    localparam logic [15:0] IDX_RESULT = 16'h0BB8;
    localparam int NUM_LINES = 23;
    localparam int NUM_FLEX = 12;
    localparam logic [31:0] FLEX_MASK = 32'h0000FFF0;
    localparam logic [31:0] PULLUP_MASK = 32'h00000FFF;
    localparam logic [31:0] RST_ZERO = 32'h00000000;
    localparam logic [3:0] SEL_W_MAX = 4'hC;

    typedef enum logic [3:0] {
        FLIO_PWM_OUT = 4'h0,
        FLIO_PWM_PHASE = 4'h1,
        FLIO_PULSE_OUT = 4'h2,
        FLIO_FREQ_IN_A = 4'h3,
        FLIO_FREQ_IN_B = 4'h4,
        FLIO_PULSE_WIDTH = 4'h5,
        FLIO_LINE_TO_LINE = 4'h6,
        FLIO_HS_COUNTER = 4'h7,
        FLIO_INT_COUNTER = 4'h8,
        FLIO_DEB_COUNTER = 4'h9,
        FLIO_QUADRATURE = 4'hA,
        FLIO_INT_FREQ = 4'hB,
        FLIO_COND_RESET = 4'hC
    } flio_feature_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } flio_bus_req_t;
endpackage : flio_pkg

// ==== flio_line_cfg.sv ====
// Bulk direction, level, analog, pull-up and extended-feature control of the digital lines.
//
// Local design decision: strobed register access.
`timescale 1ns/1ns

// Contract
// - Direction mask, 0 input, 1 output.
// - Direction writes skip blocked bits.
// - Level mask; writes never change direction.
// - Level reads return sampled terminal levels.
// - Level writes skip blocked bits.
// - Bit n controls line n.
// - Pull-up off mask, bit 0 first flex.
// - Pull-up mask ignored on fixed lines.
// - One feature set per line 0..22.
// - Run control 1 starts, 0 stops.
// - Result reads never error while stopped.
// - Feature selector decodes indices 0..12.
// - Results exposed, settings accepted live.
// - Blocking bit 1 ignores direction, level and analog mask writes.
// - Analog to digital forces input.
// - Single-line read forces input, returns level.
module flio_line_cfg #(
    parameter int LINES = flio_pkg::NUM_LINES,
    parameter int FLEX_LO = 4
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire flio_pkg::flio_bus_req_t bus_req,
    output logic [15:0] rdata,
    input wire logic [LINES-1:0] line_in,
    output logic [LINES-1:0] line_out,
    output logic [LINES-1:0] line_oe,
    output logic [LINES-1:0] pullup_en,
    output logic [LINES-1:0] analog_mode,
    output logic [LINES-1:0] feature_run,
    output logic [LINES*4-1:0] feature_sel,
    input wire logic [LINES*32-1:0] feature_result
);
    // ************************************************************
    // Decoding
    // ************************************************************
    // Masks occupy word pairs, so the low address bit only picks the half.
    function automatic logic hit(input logic [15:0] a, input logic [15:0] base);
        hit = (a[15:1] == base[15:1]);
    endfunction : hit

    function automatic logic hit_line(input logic [15:0] a, input logic [15:0] base);
        hit_line = (a >= base) && (a < base + 16'(LINES));
    endfunction : hit_line

    logic [15:0] a;
    logic wr;
    logic rd;
    logic [15:0] lidx;
    assign a = bus_req.addr;
    assign wr = bus_req.wr;
    assign rd = bus_req.rd;

    // ************************************************************
    // Pin sampling
    // ************************************************************
    logic [LINES-1:0] s1_q;
    logic [LINES-1:0] s2_q;
    logic [LINES-1:0] s3_q;
    logic [LINES-1:0] lvl_q;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            lvl_q <= '0;
        end else begin
            s1_q <= line_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // A line counts as changed once two stages agree, filtering a single glitch.
            lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
        end
    end

    // ************************************************************
    // Mask registers
    // ************************************************************
    logic [15:0] lo_hold_q;
    logic [31:0] wval;
    logic [31:0] dir_q;
    logic [31:0] out_q;
    logic [31:0] blk_q;
    logic [31:0] ana_q;
    logic [31:0] pu_q;
    logic [31:0] open_bits;
    logic [31:0] ana_next;
    logic [31:0] line_mask;
    logic wr_hi;
    logic line_wr;
    logic line_rd;
    logic [4:0] lbit;
    logic line_set;
    logic lo_wr;

    assign line_mask = 32'((64'h1 << LINES) - 64'h1);
    // high word completes the value
    // The low word waits in a holding register, so a half-written mask never reaches the pins.
    assign lo_wr = wr && !a[0];
    assign wr_hi = wr && a[0];
    assign wval = {bus_req.wdata, lo_hold_q};
    assign open_bits = ~blk_q & line_mask;
    assign ana_next = (ana_q & ~open_bits) | (wval & open_bits & flio_pkg::FLEX_MASK);
    assign lidx = a - flio_pkg::IDX_LINE;
    assign line_wr = wr && hit_line(a, flio_pkg::IDX_LINE);
    assign line_rd = rd && hit_line(a, flio_pkg::IDX_LINE);
    // The line window is shorter than 32, so five address bits select the line.
    assign lbit = lidx[4:0];
    // A line write to an analog line is dropped so that a sensor output is never driven.
    assign line_set = line_wr && !ana_q[lbit];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lo_hold_q <= 16'h0000;
        end else if (lo_wr) begin
            // low word held until high word
            lo_hold_q <= bus_req.wdata;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            blk_q <= flio_pkg::RST_ZERO;
        end else if (wr_hi && hit(a, flio_pkg::IDX_BLOCK)) begin
            blk_q <= wval & line_mask;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ana_q <= flio_pkg::RST_ZERO;
        end else if (wr_hi && hit(a, flio_pkg::IDX_ANALOG)) begin
            ana_q <= ana_next;
        end else if (line_rd) begin
            ana_q[lbit] <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dir_q <= flio_pkg::RST_ZERO;
        end else if (wr_hi && hit(a, flio_pkg::IDX_DIR)) begin
            dir_q <= (dir_q & ~open_bits) | (wval & open_bits);
        end else if (wr_hi && hit(a, flio_pkg::IDX_ANALOG)) begin
            dir_q <= dir_q & ~(ana_q & ~ana_next);
        end else if (line_rd) begin
            dir_q[lbit] <= 1'b0;
        end else if (line_set) begin
            // A line write to a digital line turns it into an output.
            dir_q[lbit] <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            out_q <= flio_pkg::RST_ZERO;
        end else if (wr_hi && hit(a, flio_pkg::IDX_LEVEL)) begin
            out_q <= (out_q & ~open_bits) | (wval & open_bits);
        end else if (line_set) begin
            out_q[lbit] <= bus_req.wdata[0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pu_q <= flio_pkg::RST_ZERO;
        end else if (wr_hi && hit(a, flio_pkg::IDX_PULLUP)) begin
            pu_q <= wval & flio_pkg::PULLUP_MASK;
        end
    end

    // ************************************************************
    // Extended-feature slots, one per line
    // ************************************************************
    logic [LINES-1:0] run_q;
    // Each slot keeps its selector while stopped, so a restart needs no rewrite.
    logic [3:0] sel_q [LINES];

    // One slot decode serves both the run control and the selector.
    function automatic logic slot_hit(input logic [15:0] a_in, input logic [15:0] base,
        input int n);
        slot_hit = (a_in[15:1] == 15'((base >> 1) + n));
    endfunction : slot_hit

    genvar g;
    generate
        for (g = 0; g < LINES; g++) begin : g_slot
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    run_q[g] <= 1'b0;
                end else if (wr_hi && slot_hit(a, flio_pkg::IDX_RUN, g)) begin
                    run_q[g] <= wval[0];
                end
            end
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    sel_q[g] <= 4'h0;
                end else if (wr_hi && slot_hit(a, flio_pkg::IDX_SEL, g)
                    && wval[3:0] <= flio_pkg::SEL_W_MAX && wval[31:4] == 28'h0) begin
                    sel_q[g] <= wval[3:0];
                end
            end
            assign feature_run[g] = run_q[g];
            assign feature_sel[g*4 +: 4] = sel_q[g];
        end
    endgenerate

    // ************************************************************
    // Pin controls
    // ************************************************************
    generate
        for (g = 0; g < LINES; g++) begin : g_pin
            assign line_out[g] = out_q[g];
            // bit g controls line g
            // A running feature owns its pin, so the direction bit is masked meanwhile.
            assign line_oe[g] = dir_q[g] & ~ana_q[g] & ~run_q[g];
            assign analog_mode[g] = ana_q[g];
            // fixed lines ignore the pull-up mask
            if (g >= FLEX_LO && g < FLEX_LO + flio_pkg::NUM_FLEX) begin : g_flex
                assign pullup_en[g] = ~dir_q[g] & ~ana_q[g] & ~pu_q[g - FLEX_LO];
            end else begin : g_fixed
                assign pullup_en[g] = ~dir_q[g];
            end
        end
    endgenerate

    // ************************************************************
    // Read path
    // ************************************************************
    function automatic logic [15:0] half(input logic [31:0] v, input logic hi);
        half = hi ? v[31:16] : v[15:0];
    endfunction : half

    logic [15:0] rd_d;
    logic [15:0] ridx;
    logic [15:0] sidx;
    logic [15:0] tidx;
    logic run_rd;
    logic sel_rd;
    logic res_rd;
    assign ridx = a - flio_pkg::IDX_RESULT;
    assign sidx = (a - flio_pkg::IDX_RUN) >> 1;
    assign tidx = (a - flio_pkg::IDX_SEL) >> 1;
    // Only even words of the run and selector slots carry data; odd words read as zero.
    assign run_rd = a >= flio_pkg::IDX_RUN && sidx < 16'(LINES) && !a[0];
    assign sel_rd = a >= flio_pkg::IDX_SEL && tidx < 16'(LINES) && !a[0];
    assign res_rd = a >= flio_pkg::IDX_RESULT && (ridx >> 1) < 16'(LINES);
    always_comb begin
        rd_d = 16'h0000;
        if (hit(a, flio_pkg::IDX_LEVEL)) begin
            rd_d = half(32'(lvl_q), a[0]);
        end else if (hit(a, flio_pkg::IDX_DIR)) begin
            rd_d = half(dir_q, a[0]);
        end else if (hit(a, flio_pkg::IDX_BLOCK)) begin
            rd_d = half(blk_q, a[0]);
        end else if (hit(a, flio_pkg::IDX_ANALOG)) begin
            rd_d = half(ana_q, a[0]);
        end else if (hit(a, flio_pkg::IDX_PULLUP)) begin
            rd_d = half(pu_q, a[0]);
        end else if (hit_line(a, flio_pkg::IDX_LINE)) begin
            rd_d = {15'h0000, lvl_q[lidx[4:0]]};
        end else if (run_rd) begin
            rd_d = {15'h0000, run_q[sidx[4:0]]};
        end else if (sel_rd) begin
            rd_d = {12'h000, sel_q[tidx[4:0]]};
        end else if (res_rd) begin
            // results read freely even when stopped
            rd_d = half(feature_result[(32'(ridx >> 1)) * 32 +: 32], a[0]);
        end
    end

    // Read data falls back to zero outside an answer, so a stale word is never taken for new.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata <= 16'h0000;
        end else if (rd) begin
            rdata <= rd_d;
        end else begin
            rdata <= 16'h0000;
        end
    end
endmodule : flio_line_cfg

// ==== flio_line_cfg_sva.sv ====
// Checker with concurrent properties for the flexible line configuration block.
`timescale 1ns/1ns
module flio_line_cfg_sva #(
    parameter int LINES = 23
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire flio_pkg::flio_bus_req_t bus_req,
    input wire logic [15:0] rdata,
    input wire logic [LINES-1:0] line_in,
    input wire logic [LINES-1:0] line_out,
    input wire logic [LINES-1:0] line_oe,
    input wire logic [LINES-1:0] pullup_en,
    input wire logic [LINES-1:0] analog_mode,
    input wire logic [LINES-1:0] feature_run,
    input wire logic [LINES*4-1:0] feature_sel,
    input wire logic [LINES*32-1:0] feature_result
);
    logic sel_bad;
    // One flag for all lines keeps the range check to a single property.
    always_comb begin
        sel_bad = 1'b0;
        for (int i = 0; i < LINES; i++) begin
            if (feature_sel[4*i +: 4] > flio_pkg::SEL_W_MAX) begin
                sel_bad = 1'b1;
            end
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // ************************************************************
    // Properties
    // ************************************************************
    rdata_idle_a: assert property (!$past(bus_req.rd) |-> rdata == 16'h0000)
        else $error("read data not zero outside a read answer");
    analog_undriven_a: assert property ((line_oe & analog_mode) == '0)
        else $error("analog line is driven");
    run_owns_pin_a: assert property ((line_oe & feature_run) == '0)
        else $error("running feature line is driven");
    pullup_input_a: assert property ((pullup_en & (line_oe | analog_mode)) == '0)
        else $error("pull-up on a non-input line");
    sel_range_a: assert property (!sel_bad)
        else $error("selector holds an undefined feature");
    mask_hold_a: assert property (!$past(bus_req.wr) && !$past(bus_req.rd)
        |-> $stable(line_oe) && $stable(analog_mode)) else $error("masks changed unasked");
    run_cause_a: assert property ($rose(feature_run[3]) |-> $past(bus_req.wr)
        && $past(bus_req.addr) == flio_pkg::IDX_RUN + 16'h0007) else $error("run rose unasked");
    sel_cause_a: assert property ($changed(feature_sel[15:12]) |-> $past(bus_req.wr)
        && $past(bus_req.addr) == flio_pkg::IDX_SEL + 16'h0007) else $error("selector moved");
    out_cause_a: assert property ($changed(line_out) |-> $past(bus_req.wr))
        else $error("output values changed without a write");
    run_start_c: cover property ($rose(feature_run[3]));
    analog_on_c: cover property ($rose(analog_mode[4]));
    level_read_c: cover property (bus_req.rd && bus_req.addr == flio_pkg::IDX_LEVEL);
endmodule : flio_line_cfg_sva

bind flio_line_cfg flio_line_cfg_sva #(.LINES(LINES)) u_sva (.ref_clk(ref_clk), .rst(rst),
    .bus_req(bus_req), .rdata(rdata), .line_in(line_in), .line_out(line_out),
    .line_oe(line_oe), .pullup_en(pullup_en), .analog_mode(analog_mode),
    .feature_run(feature_run), .feature_sel(feature_sel), .feature_result(feature_result));

// ==== tb_flio_line_cfg.sv ====
// Self-checking testbench for the flexible line configuration block.
`timescale 1ns/1ns
module tb_flio_line_cfg;
    logic ref_clk;
    logic rst;
    flio_pkg::flio_bus_req_t bus_req;
    logic [15:0] rdata;
    logic [22:0] line_in, line_out, line_oe, pullup_en, analog_mode, feature_run;
    logic [91:0] feature_sel;
    logic [735:0] feature_result;
    logic [15:0] exp_q[$];
    logic rd_p = 1'b0;
    int fail_count, checked, seed;
    logic [31:0] dir_v, blk_v, v;
    localparam logic [15:0] REGS [6] = '{flio_pkg::IDX_LEVEL, flio_pkg::IDX_DIR,
        flio_pkg::IDX_PULLUP, flio_pkg::IDX_BLOCK, flio_pkg::IDX_ANALOG, 16'h1234};
    flio_line_cfg dut (.ref_clk(ref_clk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
        .line_in(line_in), .line_out(line_out), .line_oe(line_oe), .pullup_en(pullup_en),
        .analog_mode(analog_mode), .feature_run(feature_run), .feature_sel(feature_sel),
        .feature_result(feature_result));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // ************************************************************
    // Bus tasks and result checking
    // ************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks=%0d errors=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    task automatic op(input logic w, input logic [15:0] a, input logic [15:0] d);
        bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge ref_clk);
    endtask : op
    // One quiet cycle lets a high-word write land before outputs are compared.
    task automatic idle();
        bus_req <= '0;
        @(posedge ref_clk);
    endtask : idle
    task automatic wr32(input logic [15:0] a, input logic [31:0] d);
        op(1'b1, a, d[15:0]);
        op(1'b1, a + 16'h0001, d[31:16]);
        idle();
    endtask : wr32
    task automatic rd16(input logic [15:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        op(1'b0, a, 16'h0000);
    endtask : rd16
    task automatic rd32(input logic [15:0] a, input logic [31:0] e);
        rd16(a, e[15:0]);
        rd16(a + 16'h0001, e[31:16]);
        idle();
    endtask : rd32
    always @(posedge ref_clk) begin
        if (rd_p) begin
            chk({16'h0000, rdata}, {16'h0000, exp_q.pop_front()});
        end
        rd_p <= bus_req.rd;
    end
    initial begin
        rst = 1'b1;
        bus_req = '0;
        line_in = '0;
        feature_result = '0;
        fail_count = 0;
        checked = 0;
        seed = 32'h6E866A97;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        wr32(16'h1234, 32'hFFFFFFFF);
        for (int i = 0; i < 6; i++) begin
            rd32(REGS[i], 32'h00000000);
        end
        dir_v = $random(seed) & 32'h007FFFFF;
        wr32(flio_pkg::IDX_DIR, dir_v);
        rd32(flio_pkg::IDX_DIR, dir_v);
        chk(32'(line_oe), dir_v);
        op(1'b1, flio_pkg::IDX_DIR, 16'hFFFF);
        idle();
        chk(32'(line_oe), dir_v);
        op(1'b1, flio_pkg::IDX_DIR + 16'h0001, 16'h0000);
        idle();
        dir_v = 32'h0000FFFF;
        chk(32'(line_oe), dir_v);
        blk_v = $random(seed) & 32'h007FFFFF;
        v = $random(seed) & 32'h007FFFFF;
        wr32(flio_pkg::IDX_BLOCK, blk_v);
        wr32(flio_pkg::IDX_DIR, v);
        wr32(flio_pkg::IDX_LEVEL, v);
        dir_v = (dir_v & blk_v) | (v & ~blk_v);
        rd32(flio_pkg::IDX_BLOCK, blk_v);
        rd32(flio_pkg::IDX_DIR, dir_v);
        chk(32'(line_oe), dir_v);
        chk(32'(line_out), v & ~blk_v);
        v = $random(seed) & 32'h007FFFFF;
        line_in <= v[22:0];
        repeat (6) @(posedge ref_clk);
        rd32(flio_pkg::IDX_LEVEL, v);
        wr32(flio_pkg::IDX_BLOCK, 32'h00000000);
        wr32(flio_pkg::IDX_DIR, 32'h007FFFFF);
        wr32(flio_pkg::IDX_ANALOG, 32'h007FFFFF);
        chk(32'(analog_mode), 32'h0000FFF0);
        chk(32'(line_oe), 32'h007F000F);
        wr32(flio_pkg::IDX_ANALOG, 32'h00000000);
        rd32(flio_pkg::IDX_DIR, 32'h007F000F);
        wr32(flio_pkg::IDX_DIR, 32'h00000000);
        wr32(flio_pkg::IDX_PULLUP, 32'h00000001);
        chk(32'(pullup_en), 32'h007FFFEF);
        wr32(flio_pkg::IDX_PULLUP, 32'h00000FFF);
        chk(32'(pullup_en), 32'h007F000F);
        wr32(flio_pkg::IDX_DIR, 32'h00000080);
        rd16(flio_pkg::IDX_LINE + 16'h0007, {15'h0000, v[7]});
        idle();
        chk(32'(line_oe), 32'h00000000);
        op(1'b1, flio_pkg::IDX_LINE + 16'h0007, 16'h0001);
        idle();
        chk(32'(line_oe), 32'h00000080);
        chk(32'(line_out[7]), 32'h00000001);
        wr32(flio_pkg::IDX_RUN + 16'h0006, 32'h00000000);
        chk(32'(feature_run), 32'h00000000);
        for (int s = 0; s < 14; s++) begin
            wr32(flio_pkg::IDX_SEL + 16'h0006, 32'(s));
            chk(32'(feature_sel[15:12]), 32'((s < 13) ? s : 12));
        end
        feature_result[127:96] <= v;
        rd32(flio_pkg::IDX_RESULT + 16'h0006, v);
        wr32(flio_pkg::IDX_DIR, 32'h00000008);
        wr32(flio_pkg::IDX_RUN + 16'h0006, 32'h00000001);
        chk(32'(feature_run), 32'h00000008);
        chk(32'(line_oe), 32'h00000000);
        wr32(flio_pkg::IDX_RUN + 16'h0006, 32'h00000000);
        chk(32'(line_oe), 32'h00000008);
        repeat (3) @(posedge ref_clk);
        chk(32'(exp_q.size()), 32'h00000000);
        end_of_test();
    end
endmodule : tb_flio_line_cfg
